/* File: rtl/mcv_sideband.sv */
// mac receive configuration, fault status, statistics vectors and pcs/pma controls
`timescale 1ns/1ps
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// [RULE_01] flow bit: act on pause, else forward
// [RULE_02] jumbo clear drops oversize, set unlimited
// [RULE_03] fcs bit strips or passes, always checked
// [RULE_04] vlan bit raises limit 1518 to 1522
// [RULE_05] bit1 enables receiver, bit0 holds reset
// [RULE_06] report link interrupt, remote, local faults
// [RULE_07] tx vector 26/27 bits after frame
// [RULE_08] tx byte count every cycle, 0..8
// [RULE_09] tx pause and pfc generated flags
// [RULE_10] tx length saturates at 32767
// [RULE_11] tx vlan flag when vlan enabled
// [RULE_12] tx control, underrun, mcast, bcast, good
// [RULE_13] rx vector strobe by last beat
// [RULE_14] rx length field mismatch flag
// [RULE_15] rx unsupported control opcode flag
// [RULE_16] rx pause acted-on flag
// [RULE_17] rx byte count every cycle, 0..8
// [RULE_18] rx vlan flag, oversize when not jumbo
// [RULE_19] rx control flag, saturating length
// [RULE_20] rx mcast, bcast, fcs, bad, good, pfc
// [RULE_21] client ties undefined config bits low
// [RULE_22] map pcs/pma config bits to controls
// [RULE_23] client pulses resets one cycle
// [RULE_24] statistics strobes last one cycle
module mcv_sideband #(
  parameter bit PFC_EN = 1'b0,
  parameter int TXW = PFC_EN ? 27 : 26,
  parameter int RXW = PFC_EN ? 31 : 30
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [mcv_pkg::RXC_W-1:0] i_rx_cfg,
  input wire logic [47:0] i_pause_src_addr,
  input wire logic i_tx_vlan_en,
  input wire logic [2:0] i_rs_fault,
  input wire logic [3:0] i_tx_beat_bytes,
  input wire logic i_tx_eof,
  input wire logic [15:0] i_tx_len,
  input wire mcv_pkg::mcv_frame_t i_tx_frame,
  input wire logic [3:0] i_rx_beat_bytes,
  input wire logic i_rx_eof,
  input wire logic [15:0] i_rx_len,
  input wire mcv_pkg::mcv_frame_t i_rx_frame,
  input wire logic [mcv_pkg::PCV_W-1:0] i_pcspma_cfg,
  output logic o_rx_pause_tx,
  output logic o_rx_drop_frame,
  output logic o_rx_pass_fcs,
  output logic o_rx_fcs_check,
  output logic o_rx_enable,
  output logic o_rx_reset,
  output logic [2:0] o_fault_status,
  output logic [TXW-1:0] o_tx_stats,
  output logic o_tx_stats_valid,
  output logic [RXW-1:0] o_rx_stats,
  output logic o_rx_stats_valid,
  output mcv_pkg::mcv_pcs_ctl_t o_pcs_ctl,
  output logic [mcv_pkg::PSV_W-1:0] o_pcspma_status
);

  //------------------------------------------------------------
  // shared helpers
  //------------------------------------------------------------
  // saturating 15-bit length for both vectors
  function automatic logic [14:0] sat_len(input logic [15:0] len);
    sat_len = len[15] ? mcv_pkg::LEN_SAT : len[14:0];
  endfunction : sat_len

  // byte count clamp to the legal 0..8 range
  function automatic logic [3:0] clamp8(input logic [3:0] n);
    clamp8 = (n > 4'h8) ? 4'h8 : n;
  endfunction : clamp8

  //------------------------------------------------------------
  // receive configuration decode
  //------------------------------------------------------------
  wire rx_jumbo = i_rx_cfg[mcv_pkg::RXC_JUMBO];
  wire rx_vlan_en = i_rx_cfg[mcv_pkg::RXC_VLAN];
  wire rx_is_vlan = i_rx_frame.vlan;
  // vlan allowance only widens the limit when the receiver permits tags
  wire [15:0] rx_limit = (rx_vlan_en && rx_is_vlan) ? mcv_pkg::MAX_VLAN_LEN : mcv_pkg::MAX_STD_LEN; // [RULE_04]
  wire rx_oversize = !rx_jumbo && (i_rx_len > rx_limit); // [RULE_02] [RULE_18]
  wire rx_active = i_rx_cfg[mcv_pkg::RXC_ENABLE] && !i_rx_cfg[mcv_pkg::RXC_RESET]; // [RULE_05]
  wire rx_fcs_bad = i_rx_frame.fcs_err || i_rx_frame.code_err; // [RULE_03]
  wire rx_bad = rx_fcs_bad || i_rx_frame.len_err || rx_oversize;
  wire rx_ctrl = (i_rx_frame.len_type == mcv_pkg::CTRL_TYPE);
  wire rx_is_pause = rx_ctrl && (i_rx_frame.opcode == mcv_pkg::PAUSE_OPCODE);
  wire rx_addr_ok = (i_rx_frame.dest == mcv_pkg::CTRL_MCAST) || (i_rx_frame.dest == i_pause_src_addr);
  wire rx_flow_en = i_rx_cfg[mcv_pkg::RXC_FLOW];
  // pause honoured only when flow control enabled; otherwise the frame reaches the client
  wire rx_pause_act = rx_flow_en && rx_is_pause && rx_addr_ok && !rx_bad; // [RULE_01] [RULE_16]
  wire rx_bad_opc = rx_ctrl && !rx_bad && !rx_is_pause; // [RULE_15]
  // length/type below 0x600 is a length; padded frames must total 64 client bytes
  wire rx_is_len = (i_rx_frame.len_type < 16'h0600);
  wire rx_len_range = rx_is_len && (i_rx_frame.len_err ||
    ((i_rx_frame.len_type < 16'h002e) && (i_rx_len[6:0] != mcv_pkg::PAD_MIN_DATA))); // [RULE_14]
  wire rx_mcast = i_rx_frame.dest[0] && !(&i_rx_frame.dest);
  wire rx_bcast = &i_rx_frame.dest;
  // vlan frames are left out of statistics unless receive vlan is on
  wire rx_stat_ok = rx_active && !(rx_is_vlan && !rx_vlan_en); // [RULE_04]

  //------------------------------------------------------------
  // receive statistics vector assembly
  //------------------------------------------------------------
  wire [29:0] rx_vec_base = {rx_len_range, rx_bad_opc, rx_pause_act, clamp8(i_rx_beat_bytes),
    rx_is_vlan && rx_vlan_en, rx_oversize, rx_ctrl, sat_len(i_rx_len),
    rx_mcast, rx_bcast, rx_fcs_bad, rx_bad, !rx_bad}; // [RULE_14] [RULE_18] [RULE_19] [RULE_20]
  wire [RXW-1:0] rx_vec_full;
  if (PFC_EN) begin : g_rx_pfc
    assign rx_vec_full = RXW'({i_rx_frame.pfc && !rx_bad, rx_vec_base}); // [RULE_20]
  end else begin : g_rx_nopfc
    assign rx_vec_full = RXW'(rx_vec_base);
  end

  //------------------------------------------------------------
  // transmit statistics vector assembly
  //------------------------------------------------------------
  wire tx_bad = i_tx_frame.underrun || i_tx_frame.fcs_err;
  wire tx_mcast = i_tx_frame.dest[0] && !(&i_tx_frame.dest);
  wire tx_bcast = &i_tx_frame.dest;
  wire [25:0] tx_vec_base = {i_tx_frame.pause_gen, clamp8(i_tx_beat_bytes),
    i_tx_frame.vlan && i_tx_vlan_en, sat_len(i_tx_len),
    i_tx_frame.len_type == mcv_pkg::CTRL_TYPE, i_tx_frame.underrun,
    tx_mcast, tx_bcast, !tx_bad}; // [RULE_09] [RULE_10] [RULE_11] [RULE_12]
  wire [TXW-1:0] tx_vec_full;
  if (PFC_EN) begin : g_tx_pfc
    assign tx_vec_full = TXW'({i_tx_frame.pfc, tx_vec_base}); // [RULE_09]
  end else begin : g_tx_nopfc
    assign tx_vec_full = TXW'(tx_vec_base);
  end

  //------------------------------------------------------------
  // pcs/pma configuration mapping
  //------------------------------------------------------------
  mcv_pkg::mcv_pcs_ctl_t pcs_next;
  assign pcs_next.pma_loop = i_pcspma_cfg[mcv_pkg::PCV_PMA_LOOP]; // [RULE_22]
  assign pcs_next.pma_reset = i_pcspma_cfg[mcv_pkg::PCV_PMA_RESET]; // [RULE_22] [RULE_23]
  assign pcs_next.pmd_tx_dis = i_pcspma_cfg[mcv_pkg::PCV_PMD_TX_DIS]; // [RULE_22]
  assign pcs_next.pcs_loop = i_pcspma_cfg[mcv_pkg::PCV_PCS_LOOP]; // [RULE_22]
  assign pcs_next.pcs_reset = i_pcspma_cfg[mcv_pkg::PCV_PCS_RESET]; // [RULE_22] [RULE_23]
  assign pcs_next.test_pat = i_pcspma_cfg[mcv_pkg::PCV_TP_HI:mcv_pkg::PCV_TP_LO];
  // status vector reflects the reset bits; other fields default to zero
  wire [mcv_pkg::PSV_W-1:0] psv_next = ({{(mcv_pkg::PSV_W-1){1'b0}}, pcs_next.pma_reset} << mcv_pkg::PSV_PMA_RESET) |
    ({{(mcv_pkg::PSV_W-1){1'b0}}, pcs_next.pcs_reset} << mcv_pkg::PSV_PCS_RESET);

  //------------------------------------------------------------
  // configuration and status registers
  //------------------------------------------------------------
  // registered so every output comes from a flop; one cycle of latency
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_pause_tx <= 1'b0;
      o_rx_drop_frame <= 1'b0;
      o_rx_pass_fcs <= 1'b0;
      o_rx_fcs_check <= 1'b1;
      o_rx_enable <= 1'b0;
      o_rx_reset <= 1'b1;
      o_fault_status <= 3'h0;
      o_pcs_ctl <= '0;
      o_pcspma_status <= '0;
    end else if (i_ce) begin
      o_rx_pause_tx <= i_rx_eof && rx_pause_act; // [RULE_01]
      o_rx_drop_frame <= i_rx_eof && rx_oversize; // [RULE_02]
      o_rx_pass_fcs <= i_rx_cfg[mcv_pkg::RXC_FCS_INBAND]; // [RULE_03]
      o_rx_fcs_check <= 1'b1; // [RULE_03]
      o_rx_enable <= i_rx_cfg[mcv_pkg::RXC_ENABLE]; // [RULE_05]
      o_rx_reset <= i_rx_cfg[mcv_pkg::RXC_RESET]; // [RULE_05]
      o_fault_status <= i_rs_fault; // [RULE_06]
      o_pcs_ctl <= pcs_next;
      o_pcspma_status <= psv_next;
    end
  end

  //------------------------------------------------------------
  // statistics vectors and strobes
  //------------------------------------------------------------
  // byte counts update every cycle; other fields only on end of frame
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tx_stats <= '0;
      o_tx_stats_valid <= 1'b0;
    end else if (i_ce) begin
      o_tx_stats[24:21] <= clamp8(i_tx_beat_bytes); // [RULE_08]
      if (i_tx_eof) begin
        o_tx_stats <= tx_vec_full; // [RULE_07]
      end
      o_tx_stats_valid <= i_tx_eof; // [RULE_24]
    end
  end

  // strobe lands the cycle after eof, alongside the last client beat
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_stats <= '0;
      o_rx_stats_valid <= 1'b0;
    end else if (i_ce) begin
      o_rx_stats[26:23] <= clamp8(i_rx_beat_bytes); // [RULE_17]
      if (i_rx_eof && rx_stat_ok) begin
        o_rx_stats <= rx_vec_full; // [RULE_13]
      end
      o_rx_stats_valid <= i_rx_eof && rx_stat_ok; // [RULE_13] [RULE_24]
    end
  end

endmodule : mcv_sideband

/* File: rtl/mcv_pkg.sv */
// package: field positions, widths and constants of the mac sideband vectors
package mcv_pkg;
  // receive configuration vector bit positions
  localparam int RXC_RESET = 0;
  localparam int RXC_ENABLE = 1;
  localparam int RXC_VLAN = 2;
  localparam int RXC_FCS_INBAND = 3;
  localparam int RXC_JUMBO = 4;
  localparam int RXC_FLOW = 5;
  localparam int RXC_W = 7;
  // fault status positions
  localparam int FLT_LOCAL = 0;
  localparam int FLT_REMOTE = 1;
  localparam int FLT_LINK_INT = 2;
  // frame sizes in bytes
  localparam logic [15:0] MAX_STD_LEN = 16'h05ee; // 1518
  localparam logic [15:0] MAX_VLAN_LEN = 16'h05f2; // 1522
  localparam logic [14:0] LEN_SAT = 15'h7fff; // 32,767
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [15:0] VLAN_TYPE = 16'h8100;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [47:0] CTRL_MCAST = 48'h010000c28001;
  localparam logic [6:0] PAD_MIN_DATA = 7'h40; // 64
  // pcs/pma configuration vector positions
  localparam int PCV_W = 536;
  localparam int PSV_W = 448;
  localparam int PCV_PMA_LOOP = 0;
  localparam int PCV_PMA_RESET = 15;
  localparam int PCV_PMD_TX_DIS = 16;
  localparam int PCV_PCS_LOOP = 110;
  localparam int PCV_PCS_RESET = 111;
  localparam int PCV_TP_LO = 240;
  localparam int PCV_TP_HI = 245;
  localparam int PSV_PMA_RESET = 15;
  localparam int PSV_PCS_RESET = 223;
  // per-frame summary from the datapath, end of frame
  typedef struct packed {
    logic pfc;
    logic pause_gen;
    logic vlan;
    logic ctrl;
    logic underrun;
    logic fcs_err;
    logic code_err;
    logic len_err;
    logic pause_acted;
    logic [15:0] opcode;
    logic [15:0] len_type;
    logic [47:0] dest;
  } mcv_frame_t;
  // pcs/pma control outputs
  typedef struct packed {
    logic pma_loop;
    logic pma_reset;
    logic pmd_tx_dis;
    logic pcs_loop;
    logic pcs_reset;
    logic [5:0] test_pat;
  } mcv_pcs_ctl_t;
endpackage : mcv_pkg

/* File: verification/mcv_sideband_monitor.sv */
// checker: port timing properties of the sideband block
`timescale 1ns/1ps
module mcv_sideband_monitor #(
  parameter int TXW = 26,
  parameter int RXW = 30
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [mcv_pkg::RXC_W-1:0] i_rx_cfg,
  input wire logic [2:0] i_rs_fault,
  input wire logic [3:0] i_tx_beat_bytes,
  input wire logic i_tx_eof,
  input wire logic [15:0] i_tx_len,
  input wire logic [3:0] i_rx_beat_bytes,
  input wire logic [mcv_pkg::PCV_W-1:0] i_pcspma_cfg,
  input wire logic o_rx_enable,
  input wire logic o_rx_reset,
  input wire logic o_rx_fcs_check,
  input wire logic [2:0] o_fault_status,
  input wire logic [TXW-1:0] o_tx_stats,
  input wire logic o_tx_stats_valid,
  input wire logic [RXW-1:0] o_rx_stats,
  input wire mcv_pkg::mcv_pcs_ctl_t o_pcs_ctl
);
  //----------
  // properties
  //----------
  // one clock domain, so clocking and reset are declared once
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_fault; i_ce |=> o_fault_status == $past(i_rs_fault); endproperty
  a_fault: assert property (p_fault) else $error("fault status wrong");
  property p_rx_en; i_ce |=> o_rx_enable == $past(i_rx_cfg[1]); endproperty
  a_rx_en: assert property (p_rx_en) else $error("rx enable wrong");
  property p_rx_rst; i_ce |=> o_rx_reset == $past(i_rx_cfg[0]); endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("rx reset wrong");
  property p_fcs_chk; o_rx_fcs_check; endproperty
  a_fcs_chk: assert property (p_fcs_chk) else $error("fcs check off");
  property p_tx_bytes; i_ce && i_tx_beat_bytes <= 4'h8 |=> o_tx_stats[24:21] == $past(i_tx_beat_bytes); endproperty
  a_tx_bytes: assert property (p_tx_bytes) else $error("tx byte count wrong");
  property p_rx_bytes; i_ce && i_rx_beat_bytes <= 4'h8 |=> o_rx_stats[26:23] == $past(i_rx_beat_bytes); endproperty
  a_rx_bytes: assert property (p_rx_bytes) else $error("rx byte count wrong");
  property p_tx_one; i_ce && !i_tx_eof |=> !o_tx_stats_valid; endproperty
  a_tx_one: assert property (p_tx_one) else $error("tx strobe without frame");
  property p_tx_len;
    i_ce && i_tx_eof |=> o_tx_stats_valid && o_tx_stats[19:5] == ($past(i_tx_len[15]) ? 15'h7fff : $past(i_tx_len[14:0]));
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx length wrong");
  property p_pcs_rst; i_ce |=> o_pcs_ctl.pcs_reset == $past(i_pcspma_cfg[111]); endproperty
  a_pcs_rst: assert property (p_pcs_rst) else $error("pcs reset wrong");
  c_tx: cover property (o_tx_stats_valid);
  c_pcs: cover property (o_pcs_ctl.pcs_reset);
  c_rst: cover property (o_rx_reset);
endmodule : mcv_sideband_monitor
bind mcv_sideband mcv_sideband_monitor #(.TXW(TXW), .RXW(RXW)) u_mon (.i_core_clk, .i_nrst, .i_ce, .i_rx_cfg,
  .i_rs_fault, .i_tx_beat_bytes, .i_tx_eof, .i_tx_len, .i_rx_beat_bytes, .i_pcspma_cfg, .o_rx_enable,
  .o_rx_reset, .o_rx_fcs_check, .o_fault_status, .o_tx_stats, .o_tx_stats_valid, .o_rx_stats, .o_pcs_ctl);

/* File: verification/mcv_client_model.sv */
// client model: drives the pcs/pma configuration vector
`timescale 1ns/1ps
module mcv_client_model (
  input wire logic i_clk,
  output logic [mcv_pkg::PCV_W-1:0] o_cfg
);
  //----------
  // vector driver
  //----------
  // bits that are not defined stay low for the whole run
  initial o_cfg = '0;
  // reset bits must only ever see a single-cycle pulse
  task automatic pulse(input int pos);
    @(posedge i_clk);
    o_cfg[pos] <= 1'b1;
    @(posedge i_clk);
    o_cfg[pos] <= 1'b0;
  endtask : pulse
endmodule : mcv_client_model

/* File: verification/tb_top.sv */
// testbench: drives the sideband block and compares its outputs
`timescale 1ns/1ps
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic [6:0] i_rx_cfg = 7'h02;
  logic [2:0] i_rs_fault = 3'h0;
  logic [3:0] i_tx_beat_bytes = 4'h0;
  logic [3:0] i_rx_beat_bytes = 4'h0;
  logic i_tx_eof = 1'b0;
  logic i_rx_eof = 1'b0;
  logic [15:0] i_tx_len = 16'h0;
  logic [15:0] i_rx_len = 16'h0;
  mcv_pkg::mcv_frame_t i_tx_frame = '0;
  mcv_pkg::mcv_frame_t i_rx_frame = '0;
  logic [mcv_pkg::PCV_W-1:0] i_pcspma_cfg;
  logic o_rx_pause_tx, o_rx_drop_frame, o_rx_pass_fcs, o_rx_fcs_check, o_rx_enable, o_rx_reset;
  logic o_tx_stats_valid, o_rx_stats_valid;
  logic [2:0] o_fault_status;
  logic [25:0] o_tx_stats;
  logic [29:0] o_rx_stats;
  mcv_pkg::mcv_pcs_ctl_t o_pcs_ctl;
  logic [mcv_pkg::PSV_W-1:0] o_pcspma_status;
  int errors = 0;
  int checked = 0;
  //----------
  // harness
  //----------
  always #25 i_core_clk = ~i_core_clk;
  // pause address and tx vlan are tied: no scenario here depends on them
  mcv_sideband dut (.i_core_clk, .i_nrst, .i_ce, .i_rx_cfg, .i_pause_src_addr(48'h0), .i_tx_vlan_en(1'b0),
    .i_rs_fault, .i_tx_beat_bytes, .i_tx_eof, .i_tx_len, .i_tx_frame, .i_rx_beat_bytes, .i_rx_eof,
    .i_rx_len, .i_rx_frame, .i_pcspma_cfg, .o_rx_pause_tx, .o_rx_drop_frame, .o_rx_pass_fcs,
    .o_rx_fcs_check, .o_rx_enable, .o_rx_reset, .o_fault_status, .o_tx_stats, .o_tx_stats_valid,
    .o_rx_stats, .o_rx_stats_valid, .o_pcs_ctl, .o_pcspma_status);
  mcv_client_model client (.i_clk(i_core_clk), .o_cfg(i_pcspma_cfg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // outputs land one edge after the sample, so look 1 ns past it
  task automatic tick;
    @(posedge i_core_clk);
    #1;
  endtask : tick
  task automatic frame(input logic tx, input logic rx, input logic [15:0] len, input mcv_pkg::mcv_frame_t fr);
    @(posedge i_core_clk);
    i_tx_eof <= tx;
    i_rx_eof <= rx;
    i_tx_len <= len;
    i_rx_len <= len;
    i_tx_frame <= fr;
    i_rx_frame <= fr;
    tick();
    i_tx_eof <= 1'b0;
    i_rx_eof <= 1'b0;
  endtask : frame
  // run takes well under 1000 cycles
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    mcv_pkg::mcv_frame_t fr;
    int pos[5] = '{0, 15, 16, 110, 111};
    repeat (20) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      @(posedge i_core_clk);
      i_rx_cfg <= 7'(c);
      tick();
      chk({o_rx_pass_fcs, o_rx_enable, o_rx_reset}, {c[3], c[1], c[0]});
      chk(o_rx_fcs_check, 1);
    end
    for (int f = 0; f < 8; f++) begin
      @(posedge i_core_clk);
      i_rs_fault <= 3'(f);
      tick();
      chk(o_fault_status, f);
    end
    // clock enable low must freeze the registered status
    i_ce <= 1'b0;
    i_rs_fault <= 3'h5;
    tick();
    chk(o_fault_status, 3'h7);
    i_ce <= 1'b1;
    tick();
    chk(o_fault_status, 3'h5);
    fr = '0;
    fr.ctrl = 1'b1;
    fr.len_type = mcv_pkg::CTRL_TYPE;
    fr.underrun = 1'b1;
    i_tx_beat_bytes <= 4'h8;
    i_rx_beat_bytes <= 4'h5;
    frame(1'b1, 1'b0, 16'h9000, fr);
    chk(o_tx_stats_valid, 1);
    chk(o_tx_stats[19:5], 15'h7fff);
    chk(o_tx_stats[4:3], 2'h3);
    chk(o_tx_stats[24:21], 8);
    chk(o_rx_stats[26:23], 5);
    tick();
    chk(o_tx_stats_valid, 0);
    fr.underrun = 1'b0;
    fr.len_type = mcv_pkg::CTRL_TYPE;
    fr.dest = mcv_pkg::CTRL_MCAST;
    fr.pause_acted = 1'b1;
    for (int i = 0; i < 3; i++) begin
      i_rx_cfg <= (i > 0) ? 7'h22 : 7'h02;
      fr.opcode = (i == 2) ? 16'h0002 : mcv_pkg::PAUSE_OPCODE;
      frame(1'b0, 1'b1, 16'h0040, fr);
      chk(o_rx_stats_valid, 1);
      chk(o_rx_pause_tx, i == 1);
      chk(o_rx_stats[28:27], {i == 2, i == 1});
      chk(o_rx_stats[20], 1);
    end
    fr = '0;
    for (int j = 0; j < 2; j++) begin
      i_rx_cfg <= j ? 7'h12 : 7'h02;
      frame(1'b0, 1'b1, j ? 16'h9000 : 16'h0640, fr);
      chk(o_rx_drop_frame, !j);
      chk(o_rx_stats[21:5], {!j, 1'b0, j ? 15'h7fff : 15'h0640});
    end
    fr.len_type = mcv_pkg::VLAN_TYPE;
    fr.vlan = 1'b1;
    for (int k = 0; k < 3; k++) begin
      i_rx_cfg <= (k == 0) ? 7'h00 : ((k == 1) ? 7'h02 : 7'h06);
      frame(1'b0, 1'b1, 16'h05f2, fr);
      chk(o_rx_stats_valid, k == 2);
      if (k == 2) chk(o_rx_stats[22], 1);
    end
    for (int i = 0; i < 5; i++) begin
      client.pulse(pos[i]);
      #1;
      chk(o_pcs_ctl, 11'h400 >> i);
      chk({o_pcspma_status[223], o_pcspma_status[15]}, {i == 4, i == 1});
    end
    tick();
    test_done();
  end
endmodule : tb_top
